// *** rtl/sspr_pin_router.sv ***
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "sspr_defines.svh"

// Functional notes
// - Port 4 pins 2,1,0 carry serial zero data-out, clock, data-in.
// - Port 8 pins 6,5,4 carry serial one data-out, clock, data-in.
// - Upper select 1, lower select 0 picks the serial function on a pin.
// - Port 8 pins 2..0 with that select carry serial zero.
// - Port 8 pins 6..4 with that select carry serial one.
// - Both drive bits 1 and direction 0 give a push-pull output.
// - Direction bit 1 makes the pin an input.
// - Slave mode on port 4: only data-out at bit 2 drives.
// - Slave mode on port 4: clock and data-in pins are inputs.
// - Port 4 data bits do not affect routed serial pins.
// - Master mode on port 8: data-out and clock pins drive push-pull.
// - Master mode on port 8: data-in pin is an input.
// - Slave mode on port 8: data-out drives, clock and data-in are inputs.
// - Port 8 data bits do not affect routed serial pins.
// - The function select is the same for master and slave.
// - Internal clock means master driving the clock; external means slave.
module sspr_pin_router (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // AHB-Lite slave port.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pads: port 4 pins 3..0 at bits 3..0, port 8 pins 7..0 at bits 11..4.
    input wire logic [11:0] pin_in_i,
    output logic [11:0] pin_out_o,
    output logic [11:0] pin_oe_o,
    // Serial port zero engine.
    input wire logic ser0_dout_i,
    input wire logic ser0_clk_i,
    input wire logic ser0_master_i,
    output logic ser0_din_o,
    output logic ser0_clk_in_o,
    // Serial port one engine.
    input wire logic ser1_dout_i,
    input wire logic ser1_clk_i,
    input wire logic ser1_master_i,
    output logic ser1_din_o,
    output logic ser1_clk_in_o
);

    // ****************************************************************
    // State and helpers
    // ****************************************************************

    sspr_pkg::sspr_state_t st_ff;
    sspr_pkg::sspr_state_t nxt_st;

    // Gathers the configuration bits of one pin from the register array.
    function automatic sspr_pkg::sspr_pin_cfg_t pin_cfg(
        input logic [11:0][7:0] cfg,
        input int unsigned k
    );
        sspr_pkg::sspr_pin_cfg_t c;
        logic [3:0] base;
        logic [2:0] b;
        base = (k < 4) ? 4'h0 : `SSPR_P8_FIRST;
        b = (k < 4) ? 3'(k) : 3'(k - 4);
        c.data = cfg[base + 4'(`SSPR_FLD_DATA)][b];
        c.dir = cfg[base + 4'(`SSPR_FLD_DIR)][b];
        c.con0 = cfg[base + 4'(`SSPR_FLD_CON0)][b];
        c.con1 = cfg[base + 4'(`SSPR_FLD_CON1)][b];
        c.mod0 = cfg[base + 4'(`SSPR_FLD_MOD0)][b];
        c.mod1 = cfg[base + 4'(`SSPR_FLD_MOD1)][b];
        return c;
    endfunction

    // The serial function is the upper select set with the lower one clear.
    function automatic logic is_serial(input sspr_pkg::sspr_pin_cfg_t c);
        return c.mod1 && !c.mod0;
    endfunction

    // Live routing decisions, taken from the registered configuration.
    logic s0_on_p4;
    logic s0_on_p8;
    logic s1_on_p8;
    logic s0_clk_on_p4;
    logic s0_clk_on_p8;
    logic s1_clk_on_p8;

    // Each signal follows the select bits of its own pin only.
    always_comb begin
        s0_on_p4 = is_serial(pin_cfg(st_ff.cfg, 0));
        s0_on_p8 = is_serial(pin_cfg(st_ff.cfg, 4));
        s1_on_p8 = is_serial(pin_cfg(st_ff.cfg, 8));
        s0_clk_on_p4 = is_serial(pin_cfg(st_ff.cfg, 1));
        s0_clk_on_p8 = is_serial(pin_cfg(st_ff.cfg, 5));
        s1_clk_on_p8 = is_serial(pin_cfg(st_ff.cfg, 9));
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Bus slave, pad filter, pad drivers and serial inputs.
    always_comb begin
        logic acc;
        logic hit;
        logic [3:0] idx;
        logic [15:0] widx;
        logic [7:0] rd;
        logic [3:0] base;
        logic [2:0] role;
        logic val;
        logic drv;
        logic is_clk;
        logic mst;
        sspr_pkg::sspr_pin_cfg_t c;
        acc = 1'b0;
        hit = 1'b0;
        idx = 4'h0;
        widx = 16'h0000;
        rd = 8'h00;
        base = 4'h0;
        role = 3'h0;
        val = 1'b0;
        drv = 1'b0;
        is_clk = 1'b0;
        mst = 1'b0;
        c = '0;
        nxt_st = st_ff;

        // Data phase of a write: the low byte lands in the register.
        if (st_ff.wr_pend && st_ff.wr_hit) begin
            nxt_st.cfg[st_ff.wr_idx] = hwdata_i[7:0] &
                ((st_ff.wr_idx < `SSPR_P8_FIRST) ? `SSPR_P4_MASK : `SSPR_P8_MASK);
        end

        // Address phase decode; registers sit on word addresses.
        acc = hsel_i && hready_i && htrans_i[1];
        widx = haddr_i[17:2];
        if (haddr_i[31:18] == 14'h0000) begin
            if ((widx & `SSPR_BLOCK_MASK) == `SSPR_P4_BASE && widx[2:0] <= `SSPR_FLD_MOD1) begin
                hit = 1'b1;
                idx = {1'b0, widx[2:0]};
            end else if ((widx & `SSPR_BLOCK_MASK) == `SSPR_P8_BASE &&
                         widx[2:0] <= `SSPR_FLD_STAT) begin
                hit = 1'b1;
                idx = `SSPR_P8_FIRST + {1'b0, widx[2:0]};
            end
        end
        nxt_st.wr_pend = acc && hwrite_i;
        nxt_st.wr_hit = hit && (idx < `SSPR_P8_FIRST + 4'(`SSPR_FLD_STAT));
        nxt_st.wr_idx = idx;

        // Register reads other than status use the updated array so a write just before is seen.
        if (acc && !hwrite_i) begin
            if (!hit) begin
                rd = 8'h00;
            end else if (idx == `SSPR_P8_FIRST + 4'(`SSPR_FLD_STAT)) begin
                rd = 8'h00;
                rd[`SSPR_STAT_S0_P4] = s0_on_p4;
                rd[`SSPR_STAT_S0_P8] = s0_on_p8;
                rd[`SSPR_STAT_S1_P8] = s1_on_p8;
                rd[`SSPR_STAT_S0_MST] = ser0_master_i;
                rd[`SSPR_STAT_S1_MST] = ser1_master_i;
            end else if (idx == 4'h0) begin
                rd = ((nxt_st.cfg[0] & ~nxt_st.cfg[1]) |
                      ({4'h0, st_ff.pin_lvl[3:0]} & nxt_st.cfg[1])) & `SSPR_P4_MASK;
            end else if (idx == `SSPR_P8_FIRST) begin
                rd = (nxt_st.cfg[6] & ~nxt_st.cfg[7]) | (st_ff.pin_lvl[11:4] & nxt_st.cfg[7]);
            end else begin
                rd = nxt_st.cfg[idx];
            end
            nxt_st.hrdata = {24'h00_0000, rd};
        end
        nxt_st.hreadyout = 1'b1;
        nxt_st.hresp = `SSPR_HRESP_OKAY;

        // Three-stage pad filter: a level counts once stages two and three agree.
        nxt_st.sync1 = pin_in_i;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;
        for (int k = 0; k < `SSPR_NUM_PINS; k++) begin
            if (st_ff.sync2[k] == st_ff.sync3[k]) begin
                nxt_st.pin_lvl[k] = st_ff.sync3[k];
            end
        end

        // Pad drivers, one per pin.
        for (int unsigned k = 0; k < `SSPR_NUM_PINS; k++) begin
            c = pin_cfg(st_ff.cfg, k);
            base = (k < 4) ? 4'h0 : `SSPR_PIN_P8_FIRST;
            role = 3'(k - 32'(base));
            val = c.data;
            drv = 1'b1;
            is_clk = 1'b0;
            mst = 1'b0;
            if (is_serial(c)) begin
                // Serial pins ignore the port data bit.
                if (k < 4 || role <= 3'h2) begin
                    mst = ser0_master_i;
                    case (role)
                        3'h2: val = ser0_dout_i;
                        3'h1: begin
                            val = ser0_clk_i;
                            is_clk = 1'b1;
                        end
                        3'h0: val = 1'b1;
                        default: val = 1'b1;
                    endcase
                end else begin
                    mst = ser1_master_i;
                    case (role)
                        3'h6: val = ser1_dout_i;
                        3'h5: begin
                            val = ser1_clk_i;
                            is_clk = 1'b1;
                        end
                        default: val = 1'b1;
                    endcase
                end
                // A slave never drives its clock pin; it receives the clock.
                if (is_clk && !mst) begin
                    drv = 1'b0;
                end
            end
            nxt_st.pin_out[k] = val;
            if (c.dir || !drv) begin
                nxt_st.pin_oe[k] = 1'b0;
            end else if (c.con1 && c.con0) begin
                nxt_st.pin_oe[k] = 1'b1;
            end else if (c.con1 || c.con0) begin
                nxt_st.pin_oe[k] = !val;
            end else begin
                nxt_st.pin_oe[k] = 1'b0;
            end
        end

        // Serial inputs: port 4 has precedence, idle high when unrouted.
        if (s0_on_p4) begin
            nxt_st.ser0_din = st_ff.pin_lvl[0];
        end else if (s0_on_p8) begin
            nxt_st.ser0_din = st_ff.pin_lvl[4];
        end else begin
            nxt_st.ser0_din = 1'b1;
        end
        if (s0_clk_on_p4) begin
            nxt_st.ser0_clk_in = st_ff.pin_lvl[1];
        end else if (s0_clk_on_p8) begin
            nxt_st.ser0_clk_in = st_ff.pin_lvl[5];
        end else begin
            nxt_st.ser0_clk_in = 1'b1;
        end
        nxt_st.ser1_din = s1_on_p8 ? st_ff.pin_lvl[8] : 1'b1;
        nxt_st.ser1_clk_in = s1_clk_on_p8 ? st_ff.pin_lvl[9] : 1'b1;
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // All state moves together on every rising clock edge.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
            st_ff.hreadyout <= 1'b1;
            st_ff.sync1 <= `SSPR_PAD_IDLE;
            st_ff.sync2 <= `SSPR_PAD_IDLE;
            st_ff.sync3 <= `SSPR_PAD_IDLE;
            st_ff.pin_lvl <= `SSPR_PAD_IDLE;
            st_ff.pin_out <= `SSPR_PAD_OUT_RESET;
            st_ff.ser0_din <= 1'b1;
            st_ff.ser0_clk_in <= 1'b1;
            st_ff.ser1_din <= 1'b1;
            st_ff.ser1_clk_in <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register.
    assign hrdata_o = st_ff.hrdata;
    assign hreadyout_o = st_ff.hreadyout;
    assign hresp_o = st_ff.hresp;
    assign pin_out_o = st_ff.pin_out;
    assign pin_oe_o = st_ff.pin_oe;
    assign ser0_din_o = st_ff.ser0_din;
    assign ser0_clk_in_o = st_ff.ser0_clk_in;
    assign ser1_din_o = st_ff.ser1_din;
    assign ser1_clk_in_o = st_ff.ser1_clk_in;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    property p_p4_dout_pushpull;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (st_ff.cfg[5][2] && !st_ff.cfg[4][2] && !st_ff.cfg[1][2] &&
         st_ff.cfg[3][2] && st_ff.cfg[2][2])
        |=> (pin_oe_o[2] && pin_out_o[2] == $past(ser0_dout_i));
    endproperty
    a_p4_dout_pushpull: assert property (p_p4_dout_pushpull)
        else $error("Port 4 pin 2 does not drive serial zero data-out.");

    property p_p8_s1_dout;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (st_ff.cfg[11][6] && !st_ff.cfg[10][6] && !st_ff.cfg[7][6] &&
         st_ff.cfg[9][6] && st_ff.cfg[8][6])
        |=> (pin_oe_o[10] && pin_out_o[10] == $past(ser1_dout_i));
    endproperty
    a_p8_s1_dout: assert property (p_p8_s1_dout)
        else $error("Port 8 pin 6 does not drive serial one data-out.");

    property p_dir_input;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        st_ff.cfg[1][0] && st_ff.cfg[7][0] |=> !pin_oe_o[0] && !pin_oe_o[4];
    endproperty
    a_dir_input: assert property (p_dir_input)
        else $error("Input-configured data-in pin is driven.");

    property p_slave_clk_released;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s0_clk_on_p4 && !ser0_master_i |=> !pin_oe_o[1];
    endproperty
    a_slave_clk_released: assert property (p_slave_clk_released)
        else $error("Slave drives its clock pin.");

    property p_p8_master_clk;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (s0_clk_on_p8 && ser0_master_i && !st_ff.cfg[7][1] &&
         st_ff.cfg[9][1] && st_ff.cfg[8][1])
        |=> pin_oe_o[5] && pin_out_o[5] == $past(ser0_clk_i);
    endproperty
    a_p8_master_clk: assert property (p_p8_master_clk)
        else $error("Port 8 clock pin not driven in master mode.");

    property p_p8_s0_dout;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        st_ff.cfg[11][2] && !st_ff.cfg[10][2] |=> pin_out_o[6] == $past(ser0_dout_i);
    endproperty
    a_p8_s0_dout: assert property (p_p8_s0_dout)
        else $error("Port 8 pin 2 data bit leaks onto serial output.");

    property p_din_route;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !s0_on_p4 && s0_on_p8 |=> ser0_din_o == $past(st_ff.pin_lvl[4]);
    endproperty
    a_din_route: assert property (p_din_route)
        else $error("Serial zero data-in not taken from port 8 pin 0.");

    property p_write_lands;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        st_ff.wr_pend && st_ff.wr_hit && st_ff.wr_idx == 4'h5
        |=> st_ff.cfg[5] == ($past(hwdata_i[7:0]) & `SSPR_P4_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("Write to port 4 function select did not land.");

endmodule

// *** rtl/sspr_defines.svh ***
`ifndef SSPR_DEFINES_SVH
`define SSPR_DEFINES_SVH

// Register indices; the byte address of a register is four times its index.
`define SSPR_IDX_P4_DATA 16'hF220
`define SSPR_IDX_P4_DIR 16'hF221
`define SSPR_IDX_P4_CON0 16'hF222
`define SSPR_IDX_P4_CON1 16'hF223
`define SSPR_IDX_P4_MOD0 16'hF224
`define SSPR_IDX_P4_MOD1 16'hF225
`define SSPR_IDX_P8_DATA 16'hF240
`define SSPR_IDX_P8_DIR 16'hF241
`define SSPR_IDX_P8_CON0 16'hF242
`define SSPR_IDX_P8_CON1 16'hF243
`define SSPR_IDX_P8_MOD0 16'hF244
`define SSPR_IDX_P8_MOD1 16'hF245
`define SSPR_IDX_ROUTE_STAT 16'hF246

// Block base indices and field offsets inside a block of six registers; port 8 adds the status as a seventh.
`define SSPR_P4_BASE 16'hF220
`define SSPR_P8_BASE 16'hF240
`define SSPR_BLOCK_MASK 16'hFFF8
`define SSPR_FLD_DATA 3'h0
`define SSPR_FLD_DIR 3'h1
`define SSPR_FLD_CON0 3'h2
`define SSPR_FLD_CON1 3'h3
`define SSPR_FLD_MOD0 3'h4
`define SSPR_FLD_MOD1 3'h5
`define SSPR_FLD_STAT 3'h6
`define SSPR_P8_FIRST 4'h6

// Implemented bits: port 4 has pins 3 to 0 only.
`define SSPR_P4_MASK 8'h0F
`define SSPR_P8_MASK 8'hFF
`define SSPR_CFG_RESET 8'h00

// Pad filter stages idle high after reset; pad outputs start low.
`define SSPR_PAD_IDLE 12'hFFF
`define SSPR_PAD_OUT_RESET 12'h000

// Pin positions in the flat pin vector: port 4 at 3..0, port 8 at 11..4.
`define SSPR_PIN_P8_FIRST 4'h4
`define SSPR_NUM_PINS 12

// Status bit positions.
`define SSPR_STAT_S0_P4 0
`define SSPR_STAT_S0_P8 1
`define SSPR_STAT_S1_P8 2
`define SSPR_STAT_S0_MST 3
`define SSPR_STAT_S1_MST 4

// Bus constants.
`define SSPR_HRESP_OKAY 1'b0
`define SSPR_HSIZE_WORD 3'h2

`endif

// *** rtl/sspr_pkg.sv ***
package sspr_pkg;

    // Whole state of the pin router, registered as one word.
    typedef struct packed {
        logic [11:0][7:0] cfg;
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic [11:0] sync3;
        logic [11:0] pin_lvl;
        logic wr_pend;
        logic wr_hit;
        logic [3:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic [11:0] pin_out;
        logic [11:0] pin_oe;
        logic ser0_din;
        logic ser0_clk_in;
        logic ser1_din;
        logic ser1_clk_in;
    } sspr_state_t;

    // Pad configuration of one pin, gathered from the six registers.
    typedef struct packed {
        logic data;
        logic dir;
        logic con0;
        logic con1;
        logic mod0;
        logic mod1;
    } sspr_pin_cfg_t;

endpackage

// *** rtl/sspr_unused_placeholder_none.sv ***
`timescale 1ns/10ps

// *** dv/sspr_serial_partner.sv ***
`timescale 1ns/10ps

// ****************************************************
// External serial device sitting on the shared pads.
// ****************************************************
module sspr_serial_partner (
    // Clock.
    input wire logic ref_clk_i,
    // Device pad side.
    input wire logic [11:0] pin_out_i,
    input wire logic [11:0] pin_oe_i,
    output logic [11:0] pin_in_o,
    // Which pads carry our data and clock, and their levels.
    input wire logic [11:0] din_pins_i,
    input wire logic [11:0] clk_pins_i,
    input wire logic drive_clk_i,
    input wire logic din_i,
    input wire logic clk_i
);
    logic [11:0] tog_ff = 12'ha5a;

    // Pads nobody drives show a pattern that flips every cycle.
    always @(posedge ref_clk_i) begin
        tog_ff <= ~tog_ff;
    end

    // Wire level: the device drive wins, then ours, then the noise pattern.
    always_comb begin
        for (int k = 0; k < 12; k++) begin
            if (pin_oe_i[k]) begin
                pin_in_o[k] = pin_out_i[k];
            end else if (din_pins_i[k]) begin
                pin_in_o[k] = din_i;
            end else if (clk_pins_i[k] && drive_clk_i) begin
                pin_in_o[k] = clk_i;
            end else begin
                pin_in_o[k] = tog_ff[k];
            end
        end
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
`include "sspr_defines.svh"

// ****************************************************
// Self-checking bench for the serial pin router.
// ****************************************************
module tb;
    typedef struct packed {
        logic [1:0] sel;
        logic [31:0] mask;
        logic [31:0] val;
    } sspr_note_t;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [11:0] pin_in;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic s0_dout = 1'b0;
    logic s0_clk = 1'b0;
    logic s0_mst = 1'b0;
    logic s1_dout = 1'b0;
    logic s1_clk = 1'b0;
    logic s1_mst = 1'b0;
    logic s0_din, s0_cin, s1_din, s1_cin;
    logic [11:0] din_pins = 12'h000;
    logic [11:0] clk_pins = 12'h000;
    logic p_drv = 1'b0;
    logic p_din = 1'b0;
    logic p_clk = 1'b0;
    logic chk = 1'b0;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 2;
    sspr_note_t notes[$];

    sspr_pin_router sspr_pin_router_inst (.ref_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(`SSPR_HSIZE_WORD),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .ser0_dout_i(s0_dout), .ser0_clk_i(s0_clk), .ser0_master_i(s0_mst),
        .ser0_din_o(s0_din), .ser0_clk_in_o(s0_cin), .ser1_dout_i(s1_dout),
        .ser1_clk_i(s1_clk), .ser1_master_i(s1_mst), .ser1_din_o(s1_din),
        .ser1_clk_in_o(s1_cin));

    sspr_serial_partner sspr_serial_partner_inst (.ref_clk_i(clk), .pin_out_i(pin_out),
        .pin_oe_i(pin_oe), .pin_in_o(pin_in), .din_pins_i(din_pins), .clk_pins_i(clk_pins),
        .drive_clk_i(p_drv), .din_i(p_din), .clk_i(p_clk));

    // Clock at 125 MHz.
    initial begin
        forever #4 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic complete_run(input bit timed_out);
        if (timed_out) n_mismatch++;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic compare(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    // Takes the oldest note whenever a result is due and compares it.
    always @(posedge clk) begin
        sspr_note_t nt;
        logic [31:0] obs;
        if (chk === 1'b1 && hready === 1'b1) begin
            nt = notes.pop_front();
            case (nt.sel)
                2'd0: obs = hrdata;
                2'd1: obs = {8'h00, pin_oe, pin_out};
                default: obs = {28'h000_0000, s0_din, s0_cin, s1_din, s1_cin};
            endcase
            compare(obs & nt.mask, nt.val);
            if (nt.sel == 2'd0) compare({31'h0, hresp}, {31'h0, `SSPR_HRESP_OKAY});
        end
    end

    task automatic note(input logic [1:0] s, input logic [31:0] m, input logic [31:0] v);
        notes.push_back('{s, m, v});
        chk <= 1'b1;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) complete_run(1'b1);
            @(posedge clk);
        end
    endtask

    // One single AHB-Lite word transfer; a read notes its expected data.
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       input logic [7:0] exp);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {14'h0000, idx, 2'b00};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h00_0000, wd};
        if (!wr) note(2'd0, 32'hffff_ffff, {24'h00_0000, exp});
        wait_rdy();
        chk <= 1'b0;
    endtask

    // Notes one pad or engine-side check; the caller drops chk once after its last probe.
    task automatic probe(input logic [1:0] s, input logic [31:0] m, input logic [31:0] v);
        note(s, m, v);
        @(posedge clk);
    endtask

    // Routes one serial port over three pads, then checks pads and engine side.
    task automatic route(input logic [15:0] base, input int sh, input int fl, input int st,
                         input logic mst, input logic eng);
        logic [31:0] r, m, e;
        logic [7:0] outs;
        outs = mst ? 8'h06 : 8'h04;
        s0_mst <= mst;
        s1_mst <= mst;
        p_drv <= !mst;
        din_pins <= 12'h001 << fl;
        clk_pins <= 12'h002 << fl;
        bus(1'b1, base + 16'h0005, 8'h07 << sh, 8'h00);
        bus(1'b1, base + 16'h0004, 8'h00, 8'h00);
        for (int k = 2; k < 4; k++) begin
            r = $random(seed);
            bus(1'b1, base + k[15:0], (outs | (r[7:0] & ~outs & 8'h07)) << sh, 8'h00);
        end
        bus(1'b1, base + 16'h0001, (mst ? 8'h01 : 8'h03) << sh, 8'h00);
        r = $random(seed);
        bus(1'b1, base, r[7:0], 8'h00);
        bus(1'b0, `SSPR_IDX_ROUTE_STAT, 8'h00, (8'h01 << st) | (mst ? 8'h18 : 8'h00));
        for (int i = 0; i < 2; i++) begin
            r = $random(seed);
            s0_dout <= r[1];
            s0_clk <= r[2];
            s1_dout <= r[1];
            s1_clk <= r[2];
            p_din <= r[0];
            p_clk <= ~r[0];
            repeat (8) @(posedge clk);
            m = (32'h7 << (fl + 12)) | ({24'h00_0000, outs} << fl);
            e = ({24'h00_0000, outs} << (fl + 12)) | ({29'h0, r[1], r[2], 1'b0} << fl);
            probe(2'd1, m, e & m);
            m = (mst ? 32'h2 : 32'h3) << (eng ? 0 : 2);
            e = {30'h0, r[0], ~r[0]} << (eng ? 0 : 2);
            probe(2'd2, m, e & m);
            chk <= 1'b0;
        end
        bus(1'b1, base + 16'h0005, 8'h00, 8'h00);
    endtask

    // Watchdog against a hang.
    initial begin
        #80000;
        complete_run(1'b1);
    end

    // Main sequence.
    initial begin
        logic [31:0] r;
        logic [7:0] pm;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, `SSPR_P4_BASE + k[15:0], 8'h00, 8'h00);
            bus(1'b0, `SSPR_P8_BASE + k[15:0], 8'h00, 8'h00);
        end
        for (int p = 0; p < 2; p++) begin
            pm = p ? `SSPR_P8_MASK : `SSPR_P4_MASK;
            for (int k = 0; k < 6; k++) begin
                r = $random(seed);
                bus(1'b1, (p ? `SSPR_P8_BASE : `SSPR_P4_BASE) + k[15:0], r[7:0], 8'h00);
                bus(1'b0, (p ? `SSPR_P8_BASE : `SSPR_P4_BASE) + k[15:0], 8'h00, r[7:0] & pm);
            end
            for (int k = 0; k < 6; k++) begin
                bus(1'b1, (p ? `SSPR_P8_BASE : `SSPR_P4_BASE) + k[15:0], 8'h00, 8'h00);
            end
        end
        bus(1'b1, `SSPR_IDX_ROUTE_STAT, 8'hff, 8'h00);
        bus(1'b0, `SSPR_IDX_ROUTE_STAT, 8'h00, 8'h00);
        bus(1'b1, 16'h0100, 8'h5a, 8'h00);
        bus(1'b0, 16'h0100, 8'h00, 8'h00);
        route(`SSPR_P4_BASE, 0, 0, 0, 1'b1, 1'b0);
        route(`SSPR_P4_BASE, 0, 0, 0, 1'b0, 1'b0);
        route(`SSPR_P8_BASE, 0, 4, 1, 1'b1, 1'b0);
        route(`SSPR_P8_BASE, 0, 4, 1, 1'b0, 1'b0);
        route(`SSPR_P8_BASE, 4, 8, 2, 1'b1, 1'b1);
        route(`SSPR_P8_BASE, 4, 8, 2, 1'b0, 1'b1);
        repeat (2) @(posedge clk);
        complete_run(1'b0);
    end
endmodule
